// ### src/hfs_pkg.sv
/*
 * Package for the hop frame sequencer: register map, field positions,
 * reset values and timing counts.
 * Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
 */
package hfs_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_PS            = 10000;
    localparam int TX_FE_POWERUP_TIME_NS    = 5000;
    localparam int RX_FE_POWERUP_TIME_NS    = 7000;
    localparam int RX_TX_FE_GAP_PS          = 150000;
    localparam int TX_FE_POWERUP_CYC        = (TX_FE_POWERUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
    localparam int RX_FE_POWERUP_CYC        = (RX_FE_POWERUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
    localparam int RX_TX_FE_GAP_CYC         = (RX_TX_FE_GAP_PS + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;

    localparam int CNT_W                    = 24;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_CTRL          = 8'h00;
    localparam logic [7:0] REG_TX_SWITCH     = 8'h04;
    localparam logic [7:0] REG_TX_ANALOG     = 8'h08;
    localparam logic [7:0] REG_RX_ANALOG     = 8'h0C;
    localparam logic [7:0] REG_RX_LNA        = 8'h10;
    localparam logic [7:0] REG_RX_FIRST_DATA = 8'h14;
    localparam logic [7:0] REG_RX_KEEP       = 8'h18;
    localparam logic [7:0] REG_RELOCK        = 8'h1C;
    localparam logic [7:0] REG_STATUS        = 8'h20;

    // CTRL fields
    localparam int CTRL_EN_BIT      = 0;
    localparam int CTRL_TX_BIT      = 1;
    localparam int CTRL_RETUNE_BIT  = 2;
    localparam int CTRL_ANT_OWN_BIT = 3;
    localparam int CTRL_LNA_OWN_BIT = 4;

    localparam logic [4:0]       CTRL_RST  = 5'h00;
    localparam logic [CNT_W-1:0] DELAY_RST = 24'h00_0000;
    localparam logic [31:0]      RD_ZERO   = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        HFS_IDLE = 3'b001,
        HFS_WAIT = 3'b010,
        HFS_ON   = 3'b100
    } hfs_fe_state_t;

endpackage

// ### src/hfs_delay_if.sv
/*
 * Interface that joins the sequencer to one delay timer instance.
 * Assumes both ends run on the same aclk.
 */
`timescale 1ns/100ps
interface hfs_delay_if;
    import hfs_pkg::*;
    logic             start;
    logic             stop;
    logic [CNT_W-1:0] delay;
    logic             fire;
    modport ctl (output start, output stop, output delay, input fire);
    modport tmr (input start, input stop, input delay, output fire);
endinterface

// ### src/hfs_delay_timer.sv
/*
 * One-shot delay timer: fire pulses delay cycles after start (delay 0
 * fires on the start cycle itself). Stop cancels a pending count.
 * Assumes start and stop come from logic on aclk.
 */
`timescale 1ns/100ps
module hfs_delay_timer
    import hfs_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    hfs_delay_if.tmr  dly
);
    logic [CNT_W-1:0] cnt_ff;
    logic             run_ff;

    // Zero delay answers at once, on the same cycle as start
    assign dly.fire = (dly.start && dly.delay == '0 && !dly.stop) ||
                      (run_ff && cnt_ff == CNT_W'(1) && !dly.stop);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_ff <= 1'b0;
            cnt_ff <= '0;
        end else if (dly.stop) begin
            run_ff <= 1'b0;
        end else if (dly.start && dly.delay != '0) begin
            run_ff <= 1'b1;
            cnt_ff <= dly.delay;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff - CNT_W'(1);
            if (cnt_ff == CNT_W'(1)) begin
                run_ff <= 1'b0;
            end
        end
    end
endmodule // hfs_delay_timer

// ### src/hfs_sequencer.sv
/*
 * Hop frame transmit/receive timing sequencer with AXI4-Lite registers.
 * Assumes hop_in and tx_setup_in arrive from pins (synchronised here) and
 * that the baseband keeps its own setup timing.
 */
`timescale 1ns/100ps

module hfs_sequencer
    import hfs_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        hop_in,
    input  wire logic        tx_setup_in,
    output logic             tx_analog_on,
    output logic             tx_fe_ready,
    output logic             tx_antenna_on,
    output logic             tx_if_on,
    output logic             rx_analog_on,
    output logic             rx_fe_ready,
    output logic             rx_lna_on,
    output logic             rx_if_on
);

    // ****************************************
    // Registers
    // ****************************************
    logic [4:0]       ctrl_ff;
    logic [CNT_W-1:0] tx_sw_dly_ff;
    logic [CNT_W-1:0] tx_an_dly_ff;
    logic [CNT_W-1:0] rx_an_dly_ff;
    logic [CNT_W-1:0] rx_lna_dly_ff;
    logic [CNT_W-1:0] rx_fvd_dly_ff;
    logic [CNT_W-1:0] rx_keep_dly_ff;
    logic [CNT_W-1:0] relock_ff;

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    logic [7:0]  awaddr_ff;
    logic        aw_have_ff;
    logic [31:0] wdata_ff;
    logic        w_have_ff;
    logic        wr_go;

    assign wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff    <= 1'b0;
            awaddr_ff     <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_ff && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_ff    <= 1'b0;
            wdata_ff     <= RD_ZERO;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_have_ff && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                // Partial strobes are not merged: a write with a partial strobe stores zero
                wdata_ff  <= (s_axi_wstrb == 4'hF) ? s_axi_wdata : RD_ZERO;
            end else if (wr_go) begin
                w_have_ff <= 1'b0;
            end
        end
    end

    logic wr_ok;
    assign wr_ok = (awaddr_ff[1:0] == 2'b00) && (awaddr_ff <= REG_RELOCK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic rx_an_floor;
    assign rx_an_floor = wdata_ff[CNT_W-1:0] < CNT_W'(RX_TX_FE_GAP_CYC);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff        <= CTRL_RST;
            tx_sw_dly_ff   <= DELAY_RST;
            tx_an_dly_ff   <= CNT_W'(RX_TX_FE_GAP_CYC);
            rx_an_dly_ff   <= CNT_W'(RX_TX_FE_GAP_CYC);
            rx_lna_dly_ff  <= DELAY_RST;
            rx_fvd_dly_ff  <= DELAY_RST;
            rx_keep_dly_ff <= DELAY_RST;
            relock_ff      <= DELAY_RST;
        end else if (wr_go && wr_ok) begin
            case (awaddr_ff)
                REG_CTRL:          ctrl_ff        <= wdata_ff[4:0];
                REG_TX_SWITCH:     tx_sw_dly_ff   <= wdata_ff[CNT_W-1:0];
                // Gap floor also protects transmit power-up start
                REG_TX_ANALOG:     tx_an_dly_ff   <= rx_an_floor ? CNT_W'(RX_TX_FE_GAP_CYC)
                                                     : wdata_ff[CNT_W-1:0];
                REG_RX_ANALOG:     rx_an_dly_ff   <= rx_an_floor ? CNT_W'(RX_TX_FE_GAP_CYC)
                                                     : wdata_ff[CNT_W-1:0];
                REG_RX_LNA:        rx_lna_dly_ff  <= wdata_ff[CNT_W-1:0];
                REG_RX_FIRST_DATA: rx_fvd_dly_ff  <= wdata_ff[CNT_W-1:0];
                REG_RX_KEEP:       rx_keep_dly_ff <= wdata_ff[CNT_W-1:0];
                REG_RELOCK:        relock_ff      <= wdata_ff[CNT_W-1:0];
                default:           ctrl_ff        <= ctrl_ff;
            endcase
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    logic [31:0] rd_mux;
    logic        rd_ok;

    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = RD_ZERO;
        case (s_axi_araddr)
            REG_CTRL:          rd_mux = {27'h000_0000, ctrl_ff};
            REG_TX_SWITCH:     rd_mux = {8'h00, tx_sw_dly_ff};
            REG_TX_ANALOG:     rd_mux = {8'h00, tx_an_dly_ff};
            REG_RX_ANALOG:     rd_mux = {8'h00, rx_an_dly_ff};
            REG_RX_LNA:        rd_mux = {8'h00, rx_lna_dly_ff};
            REG_RX_FIRST_DATA: rd_mux = {8'h00, rx_fvd_dly_ff};
            REG_RX_KEEP:       rd_mux = {8'h00, rx_keep_dly_ff};
            REG_RELOCK:        rd_mux = {8'h00, relock_ff};
            REG_STATUS:        rd_mux = {24'h00_0000, rx_if_on, rx_lna_on, rx_fe_ready,
                                         rx_analog_on, tx_if_on, tx_antenna_on,
                                         tx_fe_ready, tx_analog_on};
            default:           rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= RD_ZERO;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic [2:0] hop_sync_ff;
    logic [2:0] setup_sync_ff;
    logic       hop_edge;
    logic       setup_fall;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hop_sync_ff   <= 3'h0;
            setup_sync_ff <= 3'h0;
        end else begin
            hop_sync_ff   <= {hop_sync_ff[1:0], hop_in};
            setup_sync_ff <= {setup_sync_ff[1:0], tx_setup_in};
        end
    end

    assign hop_edge   = hop_sync_ff[2] ^ hop_sync_ff[1];
    assign setup_fall = setup_sync_ff[2] & ~setup_sync_ff[1];

    logic en;
    logic tx_mode;
    logic tx_start;
    logic rx_start;
    logic [CNT_W-1:0] tx_fe_cyc;
    logic [CNT_W-1:0] rx_fe_cyc;

    assign en       = ctrl_ff[CTRL_EN_BIT];
    assign tx_mode  = ctrl_ff[CTRL_TX_BIT];
    assign tx_start = hop_edge && en && tx_mode;
    assign rx_start = hop_edge && en && !tx_mode;
    assign tx_fe_cyc = ctrl_ff[CTRL_RETUNE_BIT] ? relock_ff : CNT_W'(TX_FE_POWERUP_CYC);
    assign rx_fe_cyc = ctrl_ff[CTRL_RETUNE_BIT] ? relock_ff : CNT_W'(RX_FE_POWERUP_CYC);

    // ****************************************
    // Delay timers
    // ****************************************
    hfs_delay_if d_txsw ();
    hfs_delay_if d_txan ();
    hfs_delay_if d_txfe ();
    hfs_delay_if d_rxan ();
    hfs_delay_if d_rxfe ();
    hfs_delay_if d_lna ();
    hfs_delay_if d_keep ();

    assign d_txsw.start = tx_start;
    assign d_txsw.stop  = hop_edge && !tx_start;
    assign d_txsw.delay = tx_sw_dly_ff;
    assign d_txan.start = tx_start;
    assign d_txan.stop  = hop_edge && !tx_start;
    assign d_txan.delay = tx_an_dly_ff;
    assign d_txfe.start = d_txan.fire;
    assign d_txfe.stop  = hop_edge;
    assign d_txfe.delay = tx_fe_cyc;
    assign d_rxan.start = rx_start;
    assign d_rxan.stop  = hop_edge && !rx_start;
    assign d_rxan.delay = rx_an_dly_ff;
    assign d_rxfe.start = d_rxan.fire;
    assign d_rxfe.stop  = hop_edge;
    assign d_rxfe.delay = rx_fe_cyc;
    assign d_lna.start  = rx_start && ctrl_ff[CTRL_LNA_OWN_BIT];
    assign d_lna.stop   = hop_edge && !d_lna.start;
    assign d_lna.delay  = rx_lna_dly_ff;
    // Keep window starts at the edge that ends a receive frame
    assign d_keep.start = hop_edge && rx_analog_on;
    assign d_keep.stop  = 1'b0;
    assign d_keep.delay = rx_keep_dly_ff;

    hfs_delay_timer u_txsw (.aclk(aclk), .aresetn(aresetn), .dly(d_txsw));
    hfs_delay_timer u_txan (.aclk(aclk), .aresetn(aresetn), .dly(d_txan));
    hfs_delay_timer u_txfe (.aclk(aclk), .aresetn(aresetn), .dly(d_txfe));
    hfs_delay_timer u_rxan (.aclk(aclk), .aresetn(aresetn), .dly(d_rxan));
    hfs_delay_timer u_rxfe (.aclk(aclk), .aresetn(aresetn), .dly(d_rxfe));
    hfs_delay_timer u_lna  (.aclk(aclk), .aresetn(aresetn), .dly(d_lna));
    hfs_delay_timer u_keep (.aclk(aclk), .aresetn(aresetn), .dly(d_keep));

    // ****************************************
    // Transmit outputs
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_analog_on  <= 1'b0;
            tx_fe_ready   <= 1'b0;
            tx_antenna_on <= 1'b0;
        end else if (hop_edge) begin
            // No fall-to-off delay in hopping: everything drops here
            tx_analog_on  <= 1'b0;
            tx_fe_ready   <= 1'b0;
            tx_antenna_on <= 1'b0;
        end else begin
            if (d_txan.fire) tx_analog_on <= 1'b1;
            if (d_txfe.fire) tx_fe_ready <= 1'b1;
            if (d_txsw.fire && ctrl_ff[CTRL_ANT_OWN_BIT]) tx_antenna_on <= 1'b1;
        end
    end

    // Interface is armed by setup fall; no extra latency padding here
    // An armed hop edge starts a transmit frame, an unarmed one ends it
    logic tx_armed_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_armed_ff <= 1'b0;
            tx_if_on    <= 1'b0;
        end else if (setup_fall && en && tx_mode) begin
            tx_armed_ff <= 1'b1;
            tx_if_on    <= 1'b1;
        end else if (hop_edge) begin
            tx_armed_ff <= 1'b0;
            if (!tx_armed_ff) tx_if_on <= 1'b0;
        end
    end

    // ****************************************
    // Receive outputs
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_analog_on <= 1'b0;
            rx_fe_ready  <= 1'b0;
            rx_lna_on    <= 1'b0;
        end else if (hop_edge) begin
            rx_analog_on <= 1'b0;
            rx_fe_ready  <= 1'b0;
            rx_lna_on    <= 1'b0;
        end else begin
            if (d_rxan.fire) rx_analog_on <= 1'b1;
            if (d_rxfe.fire) rx_fe_ready <= 1'b1;
            if (d_lna.fire) rx_lna_on <= 1'b1;
        end
    end

    logic keep_run_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            keep_run_ff <= 1'b0;
            rx_if_on    <= 1'b0;
        end else begin
            if (d_keep.start && rx_keep_dly_ff != DELAY_RST) keep_run_ff <= 1'b1;
            else if (d_keep.fire) keep_run_ff <= 1'b0;
            if (rx_start || d_rxan.fire) rx_if_on <= 1'b1;
            else if (d_keep.fire && !rx_analog_on) rx_if_on <= 1'b0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_TX_OFF_AT_HOP: assert property (@(posedge aclk) disable iff (!aresetn)
        hop_edge |=> !tx_analog_on && !tx_antenna_on)
        else $error("tx analog or antenna still on after hop edge");
    AST_RX_OFF_AT_HOP: assert property (@(posedge aclk) disable iff (!aresetn)
        hop_edge |=> !rx_analog_on && !rx_lna_on)
        else $error("rx analog or lna still on after hop edge");
    AST_TX_IF_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        hop_edge && !tx_armed_ff && !setup_fall |=> !tx_if_on)
        else $error("tx interface outlived the frame");
    AST_TX_IF_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        hop_edge && tx_armed_ff |=> tx_if_on)
        else $error("tx interface dropped at frame start");
    AST_TX_IF_ON: assert property (@(posedge aclk) disable iff (!aresetn)
        setup_fall && en && tx_mode |=> tx_if_on)
        else $error("tx interface not enabled by setup fall");
    // Cycles since the last hop edge, saturating; only the gap check reads it
    logic [4:0] since_hop_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            since_hop_ff <= 5'h1F;
        end else if (hop_edge) begin
            since_hop_ff <= 5'h01;
        end else if (since_hop_ff != 5'h1F) begin
            since_hop_ff <= since_hop_ff + 5'h01;
        end
    end
    AST_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
        ($rose(rx_analog_on) || $rose(tx_analog_on)) |-> since_hop_ff > 5'(RX_TX_FE_GAP_CYC))
        else $error("analog power-up inside the front-end gap");
    AST_RX_FLOOR: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_an_dly_ff >= CNT_W'(RX_TX_FE_GAP_CYC))
        else $error("rx analog delay below gap");
    AST_TX_FE_TIME: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(tx_analog_on) && !ctrl_ff[CTRL_RETUNE_BIT] |-> !tx_fe_ready [*8])
        else $error("tx front end ready too early");
    AST_RX_FE_TIME: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(rx_analog_on) && !ctrl_ff[CTRL_RETUNE_BIT] |-> !rx_fe_ready [*8])
        else $error("rx front end ready too early");
    AST_NO_OVERLAP: assert property (@(posedge aclk) disable iff (!aresetn)
        !(rx_analog_on && tx_analog_on))
        else $error("rx and tx front ends on together");

    COV_TX_FRAME: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(tx_fe_ready));
    COV_RX_FRAME: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(rx_fe_ready));
    COV_RX_KEEP: cover property (@(posedge aclk) disable iff (!aresetn)
        keep_run_ff && rx_if_on && !rx_analog_on);

endmodule // hfs_sequencer

// ### verification/hfs_bb_model.sv
/* Baseband model: drives the hop and transmit setup pins, one frame per call.
   Assumes the bench calls frame() on aclk. */
`timescale 1ns/100ps
module hfs_bb_model (
    input  wire logic aclk,
    output logic      hop_in,
    output logic      tx_setup_in
);
    initial begin
        hop_in      = 1'b0;
        tx_setup_in = 1'b0;
    end
    // Lead of 1000 cycles or more keeps setup 10 us ahead of the hop
    task automatic frame(input bit tx, input int lead);
        @(posedge aclk);
        tx_setup_in <= tx;
        repeat (lead - 50) @(posedge aclk);
        tx_setup_in <= 1'b0;
        repeat (50) @(posedge aclk);
        hop_in <= ~hop_in;
    endtask
endmodule // hfs_bb_model

// ### verification/hfs_sequencer_tb.sv
/* Self-checking bench for the hop frame sequencer.
   Assumes the baseband model and a 100 MHz aclk. */
`timescale 1ns/100ps
module hfs_sequencer_tb;
    import hfs_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, hop, setup, hop_q = 1'b0;
    logic [7:0]  awaddr, araddr, outs_q = 8'h00;
    wire  [7:0]  outs;
    logic [31:0] wdata, rdata, rd, rs = 32'h830a_d234;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rr;
    int          miscompares = 0, check_count = 0, cyc = 0, hop_t, rise[8], fall[8], sw, lna;
    always #5 aclk = ~aclk;
    hfs_bb_model hfs_bb_model_inst (.aclk(aclk), .hop_in(hop), .tx_setup_in(setup));
    hfs_sequencer hfs_sequencer_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .hop_in(hop), .tx_setup_in(setup),
        .tx_analog_on(outs[0]), .tx_fe_ready(outs[1]), .tx_antenna_on(outs[2]),
        .tx_if_on(outs[3]), .rx_analog_on(outs[4]), .rx_fe_ready(outs[5]),
        .rx_lna_on(outs[6]), .rx_if_on(outs[7]));
    // ********
    // Edge time stamps, same bit order as STATUS
    // ********
    always @(posedge aclk) begin
        cyc++;
        if (hop !== hop_q) hop_t = cyc;
        for (int i = 0; i < 8; i++) begin
            if (outs[i] === 1'b1 && outs_q[i] === 1'b0) rise[i] = cyc;
            if (outs[i] === 1'b0 && outs_q[i] === 1'b1) fall[i] = cyc;
        end
        hop_q = hop;
        outs_q = outs;
    end
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic bit near(input int t);
        return t > hop_t && t <= hop_t + 5;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ta = 0, td = 0;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        while (!(ta && td)) begin
            @(posedge aclk);
            if (awvalid && awready) ta = 1'b1;
            if (wvalid && wready) td = 1'b1;
            if (ta) awvalid <= 1'b0;
            if (td) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input int d);
        axw(a, 32'(d), rr);
        chk("write resp", RESP_OKAY, rr);
    endtask
    task automatic frm(input bit tx);
        rs = lf(rs);
        hfs_bb_model_inst.frame(tx, 1000 + rs[7:0]);
        repeat (1200) @(posedge aclk);
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        final_report();
    end
    // ********
    // Main sequence
    // ********
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            axr(8'(a * 4), rd, rr);
            chk("reset value", (a == 2 || a == 3) ? 15 : 0, rd);
        end
        axr(8'h24, rd, rr);
        chk("unmapped resp", RESP_SLVERR, rr);
        axw(REG_STATUS, 32'h0000_00FF, rr);
        chk("status write resp", RESP_SLVERR, rr);
        rs = lf(rs);
        sw = 40 + rs[5:0];
        rs = lf(rs);
        lna = 30 + rs[5:0];
        wr(REG_CTRL, 'hB);
        wr(REG_TX_SWITCH, sw);
        wr(REG_TX_ANALOG, 3);
        wr(REG_RX_ANALOG, 20);
        wr(REG_RX_LNA, lna);
        wr(REG_RX_FIRST_DATA, 'h55);
        wr(REG_RX_KEEP, 200);
        wr(REG_RELOCK, 300);
        axr(REG_RX_FIRST_DATA, rd, rr);
        chk("first valid", 'h55, rd);
        frm(1);
        chk("tx if early", 1, rise[3] < hop_t && rise[3] > hop_t - 50);
        chk("tx gap", 1, rise[0] - hop_t >= 15);
        chk("switch vs analog", sw - 15, rise[2] - rise[0]);
        chk("tx fe", 500, rise[1] - rise[0]);
        axr(REG_STATUS, rd, rr);
        chk("status tx", 'h0F, rd);
        wr(REG_CTRL, 'h15);
        frm(0);
        chk("tx off", 1, near(fall[0]) && near(fall[1]) && near(fall[2]));
        chk("tx if off", 1, near(fall[3]));
        chk("rx gap", 1, rise[4] - hop_t >= 20);
        chk("lna vs analog", lna - 20, rise[6] - rise[4]);
        chk("rx relock", 300, rise[5] - rise[4]);
        wr(REG_CTRL, 'h11);
        frm(0);
        chk("rx off", 1, near(fall[4]) && near(fall[6]));
        chk("rx fe", 700, rise[5] - rise[4]);
        wr(REG_CTRL, 'hF);
        frm(1);
        chk("rx off", 1, near(fall[4]) && near(fall[5]) && near(fall[6]));
        chk("rx if keep", 1, fall[7] - hop_t >= 199 && fall[7] - hop_t <= 205);
        chk("no overlap", 1, rise[0] > fall[4]);
        chk("tx relock", 300, rise[1] - rise[0]);
        wr(REG_CTRL, 'h3);
        frm(1);
        axr(REG_STATUS, rd, rr);
        chk("status tx no antenna", 'h0B, rd);
        final_report();
    end
endmodule // hfs_sequencer_tb
